/* File: hw/rdsp_baud.v */
// oversampling tick generator for the selectable bit rates
`timescale 1ns/10ps
`include "rdsp_map.vh"
module rdsp_baud #(
   parameter DIV_W  = 18,
   parameter CLK_HZ = `RDSP_CLK_HZ
) (
   // clock and reset
   input  wire             core_clk,
   input  wire             rstn,
   // rate select and tick
   input  wire [3:0]       rate_sel,
   output reg              tick16
);

   reg  [DIV_W-1:0] cnt_q;
   wire [DIV_W-1:0] div_last;

   // ********
   // divisor lookup, sixteen ticks per bit
   // ********
   function [DIV_W-1:0] div_of;
      input [3:0] sel;
      integer rate;
      integer d;
      begin
         case (sel)
            4'h0: rate = `RDSP_BAUD_110;
            4'h1: rate = `RDSP_BAUD_150;
            4'h2: rate = `RDSP_BAUD_300;
            4'h3: rate = `RDSP_BAUD_600;
            4'h4: rate = `RDSP_BAUD_1200;
            4'h5: rate = `RDSP_BAUD_2400;
            4'h6: rate = `RDSP_BAUD_4800;
            4'h7: rate = `RDSP_BAUD_9600;
            default: rate = `RDSP_BAUD_19200;
         endcase
         d = CLK_HZ / (`RDSP_OVS * rate) - 1;
         div_of = d[DIV_W-1:0];
      end
   endfunction

   assign div_last = div_of(rate_sel);

   // >= keeps the divider sane when the rate is raised mid-count
   always @(posedge core_clk) begin
      if (!rstn) begin
         cnt_q  <= {DIV_W{1'b0}};
         tick16 <= 1'b0;
      end else if (cnt_q >= div_last) begin
         cnt_q  <= {DIV_W{1'b0}};
         tick16 <= 1'b1;
      end else begin
         cnt_q  <= cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
         tick16 <= 1'b0;
      end
   end

endmodule

/* File: hw/rdsp_map.vh */
// register map, field layout, encodings and timing constants of the port
`ifndef RDSP_MAP_VH
`define RDSP_MAP_VH

// ********
// register byte addresses
// ********
`define RDSP_A_CFG     8'h00
`define RDSP_A_DELAY   8'h04
`define RDSP_A_STAT    8'h08
`define RDSP_A_MASK    8'h0c
`define RDSP_A_RXD     8'h10
`define RDSP_A_TXD     8'h14
`define RDSP_A_RES     8'h18

// ********
// configuration fields and encodings
// ********
`define RDSP_F_BAUD    3:0
`define RDSP_F_STOP    5:4
`define RDSP_F_PAR     7:6
`define RDSP_F_FLOW    9:8
`define RDSP_F_EOL     11:10
`define RDSP_B_ECHO    12
`define RDSP_B_VERB    13
`define RDSP_B_DBG     14
`define RDSP_CFG_W     15
`define RDSP_CFG_RST   15'h0007
`define RDSP_STOP_15   2'h1
`define RDSP_STOP_2    2'h2
`define RDSP_PAR_NONE  2'h0
`define RDSP_PAR_ODD   2'h2
`define RDSP_FLOW_HW   2'h1
`define RDSP_FLOW_SW   2'h2
`define RDSP_EOL_LF    2'h0
`define RDSP_EOL_CR    2'h1
`define RDSP_EOL_CRLF  2'h2
`define RDSP_B_TXLAST  8
`define RDSP_DLY_MAX   6'h3c

// ********
// status bits
// ********
`define RDSP_ST_W      6
`define RDSP_ST_RXA    0
`define RDSP_ST_PERR   1
`define RDSP_ST_FERR   2
`define RDSP_ST_OVR    3
`define RDSP_ST_CMD    4
`define RDSP_ST_MSG    5

// ********
// characters
// ********
`define RDSP_CH_XON    8'h11
`define RDSP_CH_XOFF   8'h13
`define RDSP_CH_CR     8'h0d
`define RDSP_CH_LF     8'h0a
`define RDSP_CH_O      8'h4f
`define RDSP_CH_K      8'h4b
`define RDSP_CH_E      8'h45
`define RDSP_CH_R      8'h52

// ********
// timing
// ********
`define RDSP_CLK_HZ    250000000
`define RDSP_CLK_NS    4
`define RDSP_DLY_UNIT_MS 1000
`define RDSP_SEC_CYCLES (`RDSP_DLY_UNIT_MS * 1000000 / `RDSP_CLK_NS)
`define RDSP_OVS       16
`define RDSP_OVS_LAST  5'h0f
`define RDSP_MID_LAST  5'h07
`define RDSP_STOP15_LAST 5'h17
`define RDSP_STOP2_LAST  5'h1f
`define RDSP_BAUD_110   110
`define RDSP_BAUD_150   150
`define RDSP_BAUD_300   300
`define RDSP_BAUD_600   600
`define RDSP_BAUD_1200  1200
`define RDSP_BAUD_2400  2400
`define RDSP_BAUD_4800  4800
`define RDSP_BAUD_9600  9600
`define RDSP_BAUD_19200 19200

`endif

/* File: hw/rdsp_top.v */
// serial port on the equipment side: framing, flow, echo, replies
//
// How it works
// RULE_01: we are the DCE; host drives our receive line and RTS.
// RULE_02: bit rate chosen among nine rates from 110 to 19200.
// RULE_03: one, one and a half, or two stop bits per frame.
// RULE_04: even, odd or no parity; made on transmit, checked on receive.
// RULE_05: hardware, software or no flow control; full side pauses other.
// RULE_06: replies wait a programmable 0 to 60 seconds after a command.
// RULE_07: reply terminator is LF, CR, CR LF or LF CR.
// RULE_08: echo on returns each received character; off returns none.
// RULE_09: verbose on sends a success or failure message per command.
// RULE_10: verbose off sends nothing; result held for a host query.
// RULE_11: debug on shows each command character on the display.
// RULE_12: factory initialise leaves serial configuration unchanged.
// RULE_13: setting save and recall do not touch serial configuration.
// RULE_14: for printer use the operator turns verbose and debug off.
// RULE_15: frame is start, eight bits lsb first, parity, stop bits.
// RULE_16: software flow uses XOFF and XON; hardware uses RTS and CTS.
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`include "rdsp_map.vh"
module rdsp_top #(
   parameter SEC_CYCLES = `RDSP_SEC_CYCLES,
   parameter DW         = 32
) (
   // clock and reset
   input  wire          core_clk,
   input  wire          rstn,
   // register port
   input  wire [7:0]    reg_addr,
   input  wire [DW-1:0] reg_wdata,
   input  wire          reg_wr,
   input  wire          reg_rd,
   output reg  [DW-1:0] reg_rdata,
   output wire          irq,
   // serial pins
   input  wire          ser_rx_in,
   output reg           ser_tx_out,
   input  wire          rts_in,
   output wire          cts_out,
   // settings events
   input  wire          factory_init,
   input  wire          setting_recall,
   // display feed
   output reg           dbg_valid,
   output reg  [7:0]    dbg_char
);

   localparam S_IDLE = 3'h0;
   localparam S_STRT = 3'h1;
   localparam S_DATA = 3'h2;
   localparam S_PAR  = 3'h3;
   localparam S_STOP = 3'h4;
   localparam K_NONE = 2'h0;
   localparam K_DATA = 2'h1;
   localparam K_RES  = 2'h2;

   reg  [`RDSP_CFG_W-1:0] cfg_q;
   reg  [5:0]  dly_set_q, dly_cnt_q;
   reg  [31:0] sec_cnt_q;
   reg  [`RDSP_ST_W-1:0] st_q, mask_q, st_set;
   reg  [1:0]  res_q;
   reg         res_pend_q;
   reg  [2:0]  rx_st_q, tx_st_q;
   reg  [4:0]  rx_cnt_q, tx_cnt_q;
   reg  [2:0]  rx_bit_q, tx_bit_q;
   reg  [7:0]  rx_sh_q, tx_sh_q, hold_q, echo_q;
   reg         hold_v_q, echo_v_q, xoff_rx_q, xoff_tx_q, tx_par_q, rx_par_q;
   reg  [1:0]  msg_k_q, msg_i_q;
   reg  [7:0]  msg_b_q;
   reg         msg_ok_q, msg_last_q;
   reg  [7:0]  msg_cur, t1, t2;
   reg  [1:0]  msg_len;
   reg  [4:0]  stop_last;
   wire        tick;
   wire        par_on = cfg_q[`RDSP_F_PAR] != `RDSP_PAR_NONE;
   wire        par_odd = cfg_q[`RDSP_F_PAR] == `RDSP_PAR_ODD;
   wire        flow_hw = cfg_q[`RDSP_F_FLOW] == `RDSP_FLOW_HW;
   wire        flow_sw = cfg_q[`RDSP_F_FLOW] == `RDSP_FLOW_SW;
   wire        two_ch = cfg_q[11];
   wire        rd_stat = reg_rd && reg_addr == `RDSP_A_STAT;
   wire        rd_rxd = reg_rd && reg_addr == `RDSP_A_RXD;
   wire        wr_txd = reg_wr && reg_addr == `RDSP_A_TXD;
   wire        wr_res = reg_wr && reg_addr == `RDSP_A_RES;
   wire        resp_open = dly_cnt_q == 6'h00;
   wire        rx_done = tick && rx_st_q == S_STOP
                         && rx_cnt_q == `RDSP_OVS_LAST;
   wire        rx_par_bad = par_on
                            && (tx_par_calc(rx_sh_q) != rx_par_q);
   wire        is_flow_ch = flow_sw && (rx_sh_q == `RDSP_CH_XON
                            || rx_sh_q == `RDSP_CH_XOFF);
   wire        fc_need = flow_sw && (hold_v_q != xoff_tx_q);
   wire        tx_go = flow_hw ? rts_in : !(flow_sw && xoff_rx_q);
   wire        tx_free = tick && tx_st_q == S_IDLE;
   wire        send_fc = tx_free && fc_need;
   wire        send_echo = tx_free && !fc_need && tx_go && echo_v_q;
   wire        send_msg = tx_free && !fc_need && tx_go && !echo_v_q
                          && msg_k_q != K_NONE && resp_open;
   wire        msg_end = {1'b0, msg_i_q} == {1'b0, msg_len};

   // ********
   // bit rate
   // ********
   // cycles per second doubles as the clock rate of the divider
   rdsp_baud #(
      .CLK_HZ (SEC_CYCLES)
   ) u_baud (
      .core_clk (core_clk),
      .rstn     (rstn),
      .rate_sel (cfg_q[`RDSP_F_BAUD]),   // RULE_02
      .tick16   (tick)
   );

   function tx_par_calc;
      input [7:0] b;
      tx_par_calc = par_odd ? ~^b : ^b;   // RULE_04
   endfunction

   // ********
   // reply bytes: verbose result then terminator, or data with terminator only when flagged last
   // ********
   always @* begin
      case (cfg_q[`RDSP_F_EOL])   // RULE_07
         `RDSP_EOL_LF:   begin t1 = `RDSP_CH_LF; t2 = `RDSP_CH_LF; end
         `RDSP_EOL_CR:   begin t1 = `RDSP_CH_CR; t2 = `RDSP_CH_CR; end
         `RDSP_EOL_CRLF: begin t1 = `RDSP_CH_CR; t2 = `RDSP_CH_LF; end
         default:        begin t1 = `RDSP_CH_LF; t2 = `RDSP_CH_CR; end
      endcase
      msg_cur = msg_b_q;
      msg_len = 2'h0;
      if (msg_k_q == K_RES) begin
         msg_len = two_ch ? 2'h3 : 2'h2;
         case (msg_i_q)
            2'h0: msg_cur = msg_ok_q ? `RDSP_CH_O : `RDSP_CH_E;
            2'h1: msg_cur = msg_ok_q ? `RDSP_CH_K : `RDSP_CH_R;
            2'h2: msg_cur = t1;
            default: msg_cur = t2;
         endcase
      end else begin
         if (msg_last_q)
            msg_len = two_ch ? 2'h2 : 2'h1;
         case (msg_i_q)
            2'h0: msg_cur = msg_b_q;
            2'h1: msg_cur = t1;
            default: msg_cur = t2;
         endcase
      end
      case (cfg_q[`RDSP_F_STOP])   // RULE_03
         `RDSP_STOP_15: stop_last = `RDSP_STOP15_LAST;
         `RDSP_STOP_2:  stop_last = `RDSP_STOP2_LAST;
         default:       stop_last = `RDSP_OVS_LAST;
      endcase
   end

   // ********
   // receiver, sixteen samples per bit, decision at mid bit
   // ********
   always @(posedge core_clk) begin
      if (!rstn) begin
         rx_st_q  <= S_IDLE;
         rx_cnt_q <= 5'h00;
         rx_bit_q <= 3'h0;
         rx_sh_q  <= 8'h00;
         rx_par_q <= 1'b0;
      end else if (tick) begin
         rx_cnt_q <= rx_cnt_q + 5'h01;
         case (rx_st_q)   // RULE_15
            S_IDLE: begin
               rx_cnt_q <= 5'h00;
               if (!ser_rx_in)
                  rx_st_q <= S_STRT;
            end
            S_STRT: if (rx_cnt_q == `RDSP_MID_LAST) begin
               rx_cnt_q <= 5'h00;
               rx_bit_q <= 3'h0;
               rx_st_q  <= ser_rx_in ? S_IDLE : S_DATA;
            end
            S_DATA: if (rx_cnt_q == `RDSP_OVS_LAST) begin
               rx_cnt_q <= 5'h00;
               rx_sh_q  <= {ser_rx_in, rx_sh_q[7:1]};
               rx_bit_q <= rx_bit_q + 3'h1;
               if (rx_bit_q == 3'h7)
                  rx_st_q <= par_on ? S_PAR : S_STOP;
            end
            S_PAR: if (rx_cnt_q == `RDSP_OVS_LAST) begin
               rx_cnt_q <= 5'h00;
               rx_par_q <= ser_rx_in;
               rx_st_q  <= S_STOP;
            end
            S_STOP: if (rx_cnt_q == `RDSP_OVS_LAST)
               rx_st_q <= S_IDLE;
            default: rx_st_q <= S_IDLE;
         endcase
      end
   end

   // ********
   // transmitter
   // ********
   always @(posedge core_clk) begin
      if (!rstn) begin
         tx_st_q    <= S_IDLE;
         tx_cnt_q   <= 5'h00;
         tx_bit_q   <= 3'h0;
         tx_sh_q    <= 8'h00;
         tx_par_q   <= 1'b0;
         ser_tx_out <= 1'b1;
      end else if (tick) begin
         tx_cnt_q <= tx_cnt_q + 5'h01;
         case (tx_st_q)   // RULE_15
            S_IDLE: begin
               tx_cnt_q   <= 5'h00;
               ser_tx_out <= 1'b1;
               if (send_fc || send_echo || send_msg) begin
                  tx_sh_q <= send_fc ? (hold_v_q ? `RDSP_CH_XOFF
                             : `RDSP_CH_XON)
                             : send_echo ? echo_q : msg_cur;
                  tx_st_q    <= S_STRT;
                  ser_tx_out <= 1'b0;
               end
            end
            S_STRT: if (tx_cnt_q == `RDSP_OVS_LAST) begin
               tx_cnt_q   <= 5'h00;
               tx_bit_q   <= 3'h0;
               tx_par_q   <= tx_par_calc(tx_sh_q);
               ser_tx_out <= tx_sh_q[0];
               tx_st_q    <= S_DATA;
            end
            S_DATA: if (tx_cnt_q == `RDSP_OVS_LAST) begin
               tx_cnt_q <= 5'h00;
               tx_bit_q <= tx_bit_q + 3'h1;
               tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
               if (tx_bit_q == 3'h7) begin
                  ser_tx_out <= par_on ? tx_par_q : 1'b1;
                  tx_st_q    <= par_on ? S_PAR : S_STOP;
               end else
                  ser_tx_out <= tx_sh_q[1];
            end
            S_PAR: if (tx_cnt_q == `RDSP_OVS_LAST) begin
               tx_cnt_q   <= 5'h00;
               ser_tx_out <= 1'b1;
               tx_st_q    <= S_STOP;
            end
            S_STOP: if (tx_cnt_q == stop_last)   // RULE_03
               tx_st_q <= S_IDLE;
            default: tx_st_q <= S_IDLE;
         endcase
      end
   end

   // ********
   // flow, echo, reply sequencing, delay, registers
   // ********
   // hold register full means our input buffer is full
   assign cts_out = flow_hw ? !hold_v_q : 1'b1;   // RULE_05 RULE_16
   assign irq = |(st_q & mask_q);

   always @* begin
      st_set = {`RDSP_ST_W{1'b0}};
      st_set[`RDSP_ST_RXA]  = rx_done && !is_flow_ch;
      st_set[`RDSP_ST_PERR] = rx_done && rx_par_bad;   // RULE_04
      st_set[`RDSP_ST_FERR] = rx_done && !ser_rx_in;
      st_set[`RDSP_ST_OVR]  = rx_done && !is_flow_ch && hold_v_q
                              && !rd_rxd;
      st_set[`RDSP_ST_CMD]  = rx_done && (rx_sh_q == `RDSP_CH_CR
                              || rx_sh_q == `RDSP_CH_LF);
      st_set[`RDSP_ST_MSG]  = send_msg && msg_end;
   end

   always @(posedge core_clk) begin
      if (!rstn) begin
         cfg_q      <= `RDSP_CFG_RST;
         dly_set_q  <= 6'h00;
         dly_cnt_q  <= 6'h00;
         sec_cnt_q  <= 32'h0;
         st_q       <= {`RDSP_ST_W{1'b0}};
         mask_q     <= {`RDSP_ST_W{1'b0}};
         res_q      <= 2'h0;
         res_pend_q <= 1'b0;
         hold_q     <= 8'h00;
         hold_v_q   <= 1'b0;
         echo_q     <= 8'h00;
         echo_v_q   <= 1'b0;
         xoff_rx_q  <= 1'b0;
         xoff_tx_q  <= 1'b0;
         msg_k_q    <= K_NONE;
         msg_i_q    <= 2'h0;
         msg_b_q    <= 8'h00;
         msg_ok_q   <= 1'b0;
         msg_last_q <= 1'b0;
         dbg_valid  <= 1'b0;
         dbg_char   <= 8'h00;
         reg_rdata  <= {DW{1'b0}};
      end else begin
         dbg_valid <= 1'b0;
         // set wins over the read-to-clear
         st_q <= (rd_stat ? {`RDSP_ST_W{1'b0}} : st_q) | st_set;
         if (rd_rxd)
            hold_v_q <= 1'b0;
         if (send_echo)
            echo_v_q <= 1'b0;
         if (send_fc)
            xoff_tx_q <= hold_v_q;   // RULE_16
         if (!flow_sw)
            xoff_tx_q <= 1'b0;
         if (rx_done) begin
            if (is_flow_ch)
               xoff_rx_q <= rx_sh_q == `RDSP_CH_XOFF;   // RULE_16
            else begin
               hold_q   <= rx_sh_q;
               hold_v_q <= 1'b1;
               if (cfg_q[`RDSP_B_ECHO]) begin   // RULE_08
                  echo_q   <= rx_sh_q;
                  echo_v_q <= 1'b1;
               end
               if (cfg_q[`RDSP_B_DBG]) begin   // RULE_11
                  dbg_valid <= 1'b1;
                  dbg_char  <= rx_sh_q;
               end
            end
         end
         if (!flow_sw)
            xoff_rx_q <= 1'b0;
         // reply hold-off restarts on each command end
         if (st_set[`RDSP_ST_CMD]) begin   // RULE_06
            dly_cnt_q <= dly_set_q;
            sec_cnt_q <= 32'h0;
         end else if (!resp_open) begin
            if (sec_cnt_q == SEC_CYCLES - 1) begin
               sec_cnt_q <= 32'h0;
               dly_cnt_q <= dly_cnt_q - 6'h01;
            end else
               sec_cnt_q <= sec_cnt_q + 32'h1;
         end
         if (send_msg) begin
            msg_i_q <= msg_i_q + 2'h1;
            if (msg_end) begin
               msg_k_q <= K_NONE;
               msg_i_q <= 2'h0;
            end
         end else if (msg_k_q == K_NONE && res_pend_q) begin
            msg_k_q    <= K_RES;   // RULE_09
            msg_ok_q   <= res_q[0];
            res_pend_q <= 1'b0;
         end else if (msg_k_q == K_NONE && wr_txd) begin
            msg_k_q    <= K_DATA;
            msg_b_q    <= reg_wdata[7:0];
            msg_last_q <= reg_wdata[`RDSP_B_TXLAST];
         end
         if (wr_res) begin
            res_q <= {1'b1, reg_wdata[0]};   // RULE_10
            if (cfg_q[`RDSP_B_VERB])   // RULE_09 RULE_10
               res_pend_q <= 1'b1;
         end
         if (reg_wr && reg_addr == `RDSP_A_CFG)
            cfg_q <= reg_wdata[`RDSP_CFG_W-1:0];
         if (reg_wr && reg_addr == `RDSP_A_DELAY)
            dly_set_q <= (reg_wdata[5:0] > `RDSP_DLY_MAX) ?
                         `RDSP_DLY_MAX : reg_wdata[5:0];
         if (reg_wr && reg_addr == `RDSP_A_MASK)
            mask_q <= reg_wdata[`RDSP_ST_W-1:0];
         // cfg and delay are left alone by these events
         if (factory_init || setting_recall) begin   // RULE_12 RULE_13
            mask_q <= {`RDSP_ST_W{1'b0}};
            res_q  <= 2'h0;
         end
         reg_rdata <= {DW{1'b0}};
         if (reg_rd) begin
            case (reg_addr)
               `RDSP_A_CFG:   reg_rdata[`RDSP_CFG_W-1:0] <= cfg_q;
               `RDSP_A_DELAY: reg_rdata[5:0] <= dly_set_q;
               `RDSP_A_STAT:  reg_rdata[`RDSP_ST_W-1:0] <= st_q;
               `RDSP_A_MASK:  reg_rdata[`RDSP_ST_W-1:0] <= mask_q;
               `RDSP_A_RXD:   reg_rdata[8:0] <= {hold_v_q, hold_q};
               `RDSP_A_TXD:   reg_rdata[1:0] <= {res_pend_q,
                                                 msg_k_q == K_NONE};
               `RDSP_A_RES:   reg_rdata[1:0] <= res_q;
               default:       reg_rdata <= {DW{1'b0}};
            endcase
         end
      end
   end

endmodule

/* File: verification/rdsp_host_model.sv */
// host terminal model: sends 8N1 frames and decodes what the port sends
`timescale 1ns/10ps
module rdsp_host_model #(
   parameter BIT_CYC = 13008
) (
   // clock and serial pins
   input  wire       core_clk,
   input  wire       ser_tx_out,
   output reg        ser_rx_in,
   output reg        rts_in,
   // decoded characters
   output reg        got_valid,
   output reg  [7:0] got_byte
);
   integer i;
   initial begin
      ser_rx_in = 1'b1;
      rts_in    = 1'b1;
      got_valid = 1'b0;
      got_byte  = 8'h00;
   end
   task send_byte(input [7:0] b);
      integer   k;
      reg [9:0] f;
      begin
         f = {1'b1, b, 1'b0};
         for (k = 0; k < 10; k = k + 1) begin
            @(posedge core_clk);
            ser_rx_in <= f[k];
            repeat (BIT_CYC - 1) @(posedge core_clk);
         end
      end
   endtask
   // a bad stop bit drops the char, so the bench sees it missing
   always begin
      @(negedge ser_tx_out);
      repeat (BIT_CYC / 2) @(posedge core_clk);
      for (i = 0; i < 8; i = i + 1) begin
         repeat (BIT_CYC) @(posedge core_clk);
         got_byte[i] <= ser_tx_out;
      end
      repeat (BIT_CYC) @(posedge core_clk);
      got_valid <= ser_tx_out;
      @(posedge core_clk);
      got_valid <= 1'b0;
   end
endmodule

/* File: verification/rdsp_top_chk.sv */
// assertion checker for the serial port top, bound to its ports
`timescale 1ns/10ps
`include "rdsp_map.vh"
module rdsp_top_chk #(
   parameter SEC_CYCLES = 100,
   parameter DW         = 32
) (
   // clock, reset and register port
   input wire          core_clk,
   input wire          rstn,
   input wire [7:0]    reg_addr,
   input wire [DW-1:0] reg_wdata,
   input wire          reg_wr,
   input wire          reg_rd,
   input wire [DW-1:0] reg_rdata,
   input wire          irq,
   // serial pins and events
   input wire          ser_rx_in,
   input wire          ser_tx_out,
   input wire          rts_in,
   input wire          cts_out,
   input wire          factory_init,
   input wire          setting_recall,
   input wire          dbg_valid,
   input wire [7:0]    dbg_char
);
   reg [14:0] cfg_q;
   reg [5:0]  mask_q;
   reg [1:0]  res_q;
   wire       clr = factory_init | setting_recall;
   // cfg shadow ignores the settings events on purpose: config must survive them; mask and result shadows clear
   always @(posedge core_clk) begin
      if (!rstn) begin
         cfg_q  <= `RDSP_CFG_RST;
         mask_q <= 6'h00;
         res_q  <= 2'h0;
      end else begin
         if (reg_wr && reg_addr == `RDSP_A_CFG)
            cfg_q <= reg_wdata[14:0];
         if (clr)
            mask_q <= 6'h00;
         else if (reg_wr && reg_addr == `RDSP_A_MASK)
            mask_q <= reg_wdata[5:0];
         if (clr)
            res_q <= 2'h0;
         else if (reg_wr && reg_addr == `RDSP_A_RES)
            res_q <= {1'b1, reg_wdata[0]};
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   property p_cfg_read;
      reg_rd && reg_addr == `RDSP_A_CFG |=> reg_rdata == {17'h0, cfg_q};
   endproperty
   a_cfg_read: assert property (p_cfg_read)
      else $error("config readback wrong");
   property p_res_read;
      reg_rd && reg_addr == `RDSP_A_RES |=> reg_rdata == {30'h0, res_q};
   endproperty
   a_res_read: assert property (p_res_read)
      else $error("result readback wrong");
   property p_mask_irq;
      mask_q == 6'h00 |-> !irq;
   endproperty
   a_mask_irq: assert property (p_mask_irq)
      else $error("interrupt while all masked");
   property p_cts_free;
      cfg_q[9:8] != `RDSP_FLOW_HW |-> cts_out;
   endproperty
   a_cts_free: assert property (p_cts_free)
      else $error("clear to send low outside hardware flow");
   property p_rst_idle;
      disable iff (1'b0)
      !rstn |=> ser_tx_out && cts_out && !irq && !dbg_valid;
   endproperty
   a_rst_idle: assert property (p_rst_idle)
      else $error("outputs not idle after reset");
   property p_start_bit;
      $fell(ser_tx_out) |=> !ser_tx_out [*8];
   endproperty
   a_start_bit: assert property (p_start_bit)
      else $error("start bit too short");
   property p_dbg_off;
      !cfg_q[14] |-> !dbg_valid;
   endproperty
   a_dbg_off: assert property (p_dbg_off)
      else $error("display feed while debug off");
   property p_dbg_pulse;
      dbg_valid |=> !dbg_valid;
   endproperty
   a_dbg_pulse: assert property (p_dbg_pulse)
      else $error("display strobe longer than one cycle");
   property p_dbg_hold;
      $changed(dbg_char) |-> dbg_valid;
   endproperty
   a_dbg_hold: assert property (p_dbg_hold)
      else $error("display char changed without strobe");
endmodule
bind rdsp_top rdsp_top_chk #(.SEC_CYCLES(SEC_CYCLES), .DW(DW)) i_rdsp_top_chk (
   .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .irq(irq), .ser_rx_in(ser_rx_in),
   .ser_tx_out(ser_tx_out), .rts_in(rts_in), .cts_out(cts_out),
   .factory_init(factory_init), .setting_recall(setting_recall),
   .dbg_valid(dbg_valid), .dbg_char(dbg_char));

/* File: verification/testbench.sv */
// self-checking bench for the serial port top
`timescale 1ns/10ps
`include "rdsp_map.vh"
module testbench;
   // scaled clock rate so a 19200 bit lasts 64 cycles
   localparam integer SEC = 1228800;
   localparam integer BIT = 16 * (SEC / (16 * `RDSP_BAUD_19200));
   localparam integer LIMIT = 20000;
   reg         core_clk;
   reg         rstn;
   reg  [7:0]  reg_addr;
   reg  [31:0] reg_wdata;
   reg         reg_wr;
   reg         reg_rd;
   reg         factory_init;
   reg         setting_recall;
   wire [31:0] reg_rdata;
   wire        irq;
   wire        ser_rx_in;
   wire        ser_tx_out;
   wire        rts_in;
   wire        cts_out;
   wire        dbg_valid;
   wire [7:0]  dbg_char;
   wire        got_valid;
   wire [7:0]  got_byte;
   integer     errors;
   integer     checks;
   integer     cyc;
   integer     k;
   reg         rd_q;
   reg  [31:0] rq[$];
   reg  [7:0]  sq[$];
   reg  [7:0]  dq[$];
   reg  [7:0]  b;
   reg  [31:0] seed_v;
   initial core_clk = 1'b0;
   always #2 core_clk = ~core_clk;
   rdsp_top #(.SEC_CYCLES(SEC), .DW(32)) i_rdsp_top (
      .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq), .ser_rx_in(ser_rx_in),
      .ser_tx_out(ser_tx_out), .rts_in(rts_in), .cts_out(cts_out),
      .factory_init(factory_init), .setting_recall(setting_recall),
      .dbg_valid(dbg_valid), .dbg_char(dbg_char));
   rdsp_host_model #(.BIT_CYC(BIT)) i_rdsp_host_model (
      .core_clk(core_clk), .ser_tx_out(ser_tx_out), .ser_rx_in(ser_rx_in),
      .rts_in(rts_in), .got_valid(got_valid), .got_byte(got_byte));
   // ********
   // tasks
   // ********
   task check(input [63:0] name, input [31:0] seen, input [31:0] exp);
      begin
         checks = checks + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("Error %0s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   task final_report;
      begin
         $display("checks %0d errors %0d", checks, errors);
         if (errors == 0 && checks > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge core_clk);
         reg_addr  <= a;
         reg_wdata <= d;
         reg_wr    <= 1'b1;
         @(posedge core_clk);
         reg_wr    <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [31:0] e);
      begin
         rq.push_back(e);
         @(posedge core_clk);
         reg_addr <= a;
         reg_rd   <= 1'b1;
         @(posedge core_clk);
         reg_rd   <= 1'b0;
      end
   endtask
   task settle_evt(input sel);
      begin
         @(posedge core_clk);
         factory_init   <= !sel;
         setting_recall <= sel;
         @(posedge core_clk);
         factory_init   <= 1'b0;
         setting_recall <= 1'b0;
      end
   endtask
   // the send engine drops new bytes until the last byte of the previous reply has started
   task drain;
      begin
         while (sq.size() != 0)
            @(posedge core_clk);
         repeat (BIT) @(posedge core_clk);
      end
   endtask
   // ********
   // watchers
   // ********
   always @(posedge core_clk) begin
      rd_q <= reg_rd;
      cyc  <= cyc + 1;
      if (rd_q)
         check("rdata", reg_rdata, rq.pop_front());
      if (got_valid)
         check("tx_char", got_byte, sq.size() ? sq.pop_front() : 8'hxx);
      if (dbg_valid)
         check("dbg_char", dbg_char, dq.size() ? dq.pop_front() : 8'hxx);
      if (cyc == LIMIT) begin
         errors = errors + 1;
         final_report;
      end
   end
   // ********
   // main sequence
   // ********
   initial begin
      rstn = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      factory_init = 1'b0;
      setting_recall = 1'b0;
      errors = 0;
      checks = 0;
      cyc = 0;
      rd_q = 1'b0;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      seed_v = $urandom(6);
      rd(`RDSP_A_CFG, 32'h7);
      rd(`RDSP_A_DELAY, 32'h0);
      rd(8'h20, 32'h0);
      rd(`RDSP_A_TXD, 32'h1);
      wr(`RDSP_A_DELAY, 32'h3f);
      rd(`RDSP_A_DELAY, 32'h3c);
      wr(`RDSP_A_DELAY, 32'h0);
      // 19200, cr lf, echo and debug on
      wr(`RDSP_A_CFG, 32'h5808);
      rd(`RDSP_A_CFG, 32'h5808);
      wr(`RDSP_A_MASK, 32'h1);
      seed_v = $urandom;
      b = {2'h1, seed_v[5:0]};
      sq.push_back(b);
      dq.push_back(b);
      i_rdsp_host_model.send_byte(b);
      check("irq", {31'h0, irq}, 32'h1);
      rd(`RDSP_A_STAT, 32'h1);
      rd(`RDSP_A_RXD, {23'h0, 1'b1, b});
      check("irq", {31'h0, irq}, 32'h0);
      drain;
      seed_v = $urandom;
      sq.push_back(seed_v[7:0]);
      sq.push_back(`RDSP_CH_CR);
      sq.push_back(`RDSP_CH_LF);
      wr(`RDSP_A_TXD, {23'h0, 1'b1, seed_v[7:0]});
      drain;
      wr(`RDSP_A_CFG, 32'h0408);
      wr(`RDSP_A_RES, 32'h0);
      rd(`RDSP_A_RES, 32'h2);
      wr(`RDSP_A_CFG, 32'h2408);
      sq.push_back(`RDSP_CH_O);
      sq.push_back(`RDSP_CH_K);
      sq.push_back(`RDSP_CH_CR);
      wr(`RDSP_A_RES, 32'h1);
      rd(`RDSP_A_RES, 32'h3);
      drain;
      for (k = 0; k < 2; k = k + 1) begin
         wr(`RDSP_A_MASK, 32'h3f);
         settle_evt(k[0]);
         rd(`RDSP_A_CFG, 32'h2408);
         rd(`RDSP_A_MASK, 32'h0);
         rd(`RDSP_A_RES, 32'h0);
      end
      repeat (4) @(posedge core_clk);
      final_report;
   end
endmodule
